// ### src/brt_pkg.sv
// Package for the boundary run-test engine: chain layout, opcodes and feedback taps.
// Assumes the engine sits behind a JTAG TAP controller that runs on the test clock.
package brt_pkg;

  // Boundary chain layout: 40 data cells below 12 control cells at 47 down to 36.
  localparam int DATA_W = 40;
  localparam int HALF_W = 20;
  localparam int CTRL_HI = 47;
  localparam int CTRL_LO = 36;
  localparam int OE_AB_POS = 47;
  localparam int OE_BA_POS = 46;
  localparam int OP_W = 3;

  // Reset values; control cells come up with both directions disabled.
  localparam logic [OP_W-1:0] OP_SEL_RST = 3'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 40'h0000000000;
  localparam logic [CTRL_HI:CTRL_LO] CTRL_RST = 12'hFFF;

  // Maximal-length taps: x^40+x^38+x^21+x^19+1 and x^20+x^17+1.
  localparam logic [DATA_W-1:0] LFSR40_TAPS = 40'hA000140000;
  localparam logic [HALF_W-1:0] LFSR20_TAPS = 20'h90000;

  // Test operations selected by the low three bits of the select register.
  typedef enum logic [2:0] {
    BRT_OP_TOGGLE = 3'b000,
    BRT_OP_PATTERN = 3'b001,
    BRT_OP_SIGNATURE = 3'b010,
    BRT_OP_SIG_PAT = 3'b011,
    BRT_OP_SIG_CNT = 3'b111
  } brt_op_e;

  // Bit 2 only matters when the low bits are 11.
  function automatic brt_op_e decode_op(input logic [OP_W-1:0] code);
    case (code)
      3'b011: decode_op = BRT_OP_SIG_PAT;
      3'b111: decode_op = BRT_OP_SIG_CNT;
      3'b001, 3'b101: decode_op = BRT_OP_PATTERN;
      3'b010, 3'b110: decode_op = BRT_OP_SIGNATURE;
      default: decode_op = BRT_OP_TOGGLE;
    endcase
  endfunction

  // Fibonacci steps; an all-zero state stays zero because feedback is pure XOR.
  function automatic logic [DATA_W-1:0] lfsr40(input logic [DATA_W-1:0] s);
    lfsr40 = {s[DATA_W-2:0], ^(s & LFSR40_TAPS)};
  endfunction

  function automatic logic [HALF_W-1:0] lfsr20(input logic [HALF_W-1:0] s);
    lfsr20 = {s[HALF_W-2:0], ^(s & LFSR20_TAPS)};
  endfunction

endpackage

// ### src/brt_sync.sv
// Two-flop level synchroniser with a synchronous clear.
// Assumes the input is a level that stays put for several destination clocks.
`timescale 1ns/1ps
module brt_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic clr,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] q;
  } brt_sync_s;

  brt_sync_s sync_reg;
  brt_sync_s sync_next;

  // The first stage feeds only the second stage, never any logic.
  always_comb begin
    sync_next.meta = d;
    sync_next.q = sync_reg.meta;
    if (clr) begin
      sync_next = '0;
    end
  end

  // Both stages register on every rising edge.
  always_ff @(posedge clk) begin
    sync_reg <= sync_next;
  end

  assign q = sync_reg.q;

endmodule // brt_sync

// ### src/brt_engine.sv
// Boundary run-test engine: select register, bypass bit, boundary cells and shadows.
// Assumes a TAP controller on tck supplies instruction and state decodes on that clock,
// and that I/O pins are asynchronous to tck.
`timescale 1ns/1ps

module brt_engine (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tdi,
  input wire logic instr_run_test,
  input wire logic instr_ctrl_scan,
  input wire logic instr_chain_scan,
  input wire logic tap_capture_dr,
  input wire logic tap_shift_dr,
  input wire logic tap_update_dr,
  input wire logic tap_run_idle,
  input wire logic [19:0] pin_a_in,
  input wire logic [19:0] pin_b_in,
  output logic [19:0] pin_a_out,
  output logic pin_a_oe,
  output logic [19:0] pin_b_out,
  output logic pin_b_oe,
  output logic tdo,
  output logic test_mode,
  output logic sys_run_active,
  output logic [2:0] sys_op_code
);

  localparam int HW = brt_pkg::HALF_W;

  // Rising-edge state: select register, bypass bit, boundary shift elements.
  typedef struct packed {
    logic [brt_pkg::OP_W-1:0] test_op_select;
    logic bypass;
    logic [brt_pkg::CTRL_HI:brt_pkg::CTRL_LO] ctrl;
    logic [brt_pkg::DATA_W-1:0] data;
    logic run_flag;
  } brt_core_s;

  // Falling-edge state: shadow latches and pin drivers.
  typedef struct packed {
    logic [brt_pkg::CTRL_HI:brt_pkg::CTRL_LO] ctrl;
    logic [brt_pkg::DATA_W-1:0] data;
    logic a_oe;
    logic b_oe;
    logic tdo;
    logic test_mode;
  } brt_shadow_s;

  brt_core_s core_reg;
  brt_core_s core_next;
  brt_shadow_s shadow_reg;
  brt_shadow_s shadow_next;

  logic rst_tck;
  logic [2*HW-1:0] pins_sync;
  logic [HW-1:0] pin_a_s;
  logic [HW-1:0] pin_b_s;
  logic a_is_input;
  logic run_active;
  brt_pkg::brt_op_e op;
  logic [HW-1:0] in_cells;
  logic [HW-1:0] out_cells;
  logic [HW-1:0] in_pins;
  logic [brt_pkg::DATA_W-1:0] ordered;
  logic [brt_pkg::DATA_W-1:0] step40;
  logic [HW-1:0] new_in;
  logic [HW-1:0] new_out;

  // Reset reaches tck through two flops, since rst belongs to sys_clk.
  brt_sync #(.WIDTH(1)) u_rst_sync (
    .clk(tck),
    .clr(1'b0),
    .d(rst),
    .q(rst_tck)
  );

  // Pin levels are asynchronous to tck, so they pass two flops first.
  brt_sync #(.WIDTH(2 * HW)) u_pin_sync (
    .clk(tck),
    .clr(rst_tck),
    .d({pin_b_in, pin_a_in}),
    .q(pins_sync)
  );

  // Status for the system side; the op code only changes during a scan, so
  // a per-bit crossing is acceptable once the scan has settled.
  brt_sync #(.WIDTH(4)) u_sys_sync (
    .clk(sys_clk),
    .clr(rst),
    .d({core_reg.run_flag, core_reg.test_op_select}),
    .q({sys_run_active, sys_op_code})
  );

  assign pin_a_s = pins_sync[HW-1:0];
  assign pin_b_s = pins_sync[2*HW-1:HW];

  // Direction decode from the current control cells, operation decode from the select register.
  always_comb begin
    a_is_input = ~core_reg.ctrl[brt_pkg::OE_AB_POS];
    op = brt_pkg::decode_op(core_reg.test_op_select);
    run_active = instr_run_test && tap_run_idle
      && (core_reg.ctrl[brt_pkg::OE_AB_POS] != core_reg.ctrl[brt_pkg::OE_BA_POS]);
    in_cells = a_is_input ? core_reg.data[HW-1:0] : core_reg.data[2*HW-1:HW];
    out_cells = a_is_input ? core_reg.data[2*HW-1:HW] : core_reg.data[HW-1:0];
    in_pins = a_is_input ? pin_a_s : pin_b_s;
    ordered = {out_cells, in_cells};
    step40 = brt_pkg::lfsr40(ordered);
  end

  // Per-mode next values of the input-side and output-side cells.
  always_comb begin
    new_in = in_cells;
    new_out = out_cells;
    case (op)
      brt_pkg::BRT_OP_TOGGLE: begin
        new_in = in_pins;
        new_out = ~out_cells;
      end
      brt_pkg::BRT_OP_PATTERN: begin
        {new_out, new_in} = step40;
      end
      brt_pkg::BRT_OP_SIGNATURE: begin
        {new_out, new_in} = step40 ^ {{HW{1'b0}}, in_pins};
      end
      brt_pkg::BRT_OP_SIG_PAT: begin
        new_in = brt_pkg::lfsr20(in_cells) ^ in_pins;
        new_out = brt_pkg::lfsr20(out_cells);
      end
      brt_pkg::BRT_OP_SIG_CNT: begin
        new_in = brt_pkg::lfsr20(in_cells) ^ in_pins;
        new_out = out_cells + 20'h00001;
      end
      default: begin
        new_in = in_cells;
        new_out = out_cells;
      end
    endcase
  end

  // Rising-edge next state. Scans and run-test never overlap, since the TAP
  // cannot be in Shift-DR and Run-Test/Idle at once.
  always_comb begin
    core_next = core_reg;
    core_next.run_flag = run_active;
    if (tap_capture_dr && instr_run_test) begin
      core_next.bypass = 1'b0;
    end
    if (tap_shift_dr) begin
      if (instr_run_test) begin
        core_next.bypass = tdi;
      end else if (instr_ctrl_scan) begin
        core_next.test_op_select = {tdi, core_reg.test_op_select[2:1]};
      end else if (instr_chain_scan) begin
        {core_next.ctrl, core_next.data} = {tdi, core_reg.ctrl, core_reg.data[39:1]};
      end
    end
    // Control cells are left out of every operation; only data cells move.
    if (run_active) begin
      core_next.data = a_is_input ? {new_out, new_in} : {new_in, new_out};
    end
    if (rst_tck) begin
      core_next.test_op_select = brt_pkg::OP_SEL_RST;
      core_next.bypass = 1'b0;
      core_next.ctrl = brt_pkg::CTRL_RST;
      core_next.data = brt_pkg::DATA_RST;
      core_next.run_flag = 1'b0;
    end
  end

  always_ff @(posedge tck) begin
    core_reg <= core_next;
  end

  // Falling-edge shadows. The decision uses rising-edge registered state so
  // the shadow never races the TAP inputs that move on this same edge.
  always_comb begin
    shadow_next = shadow_reg;
    if (core_reg.run_flag && (op != brt_pkg::BRT_OP_SIGNATURE)) begin
      shadow_next.data = core_reg.data;
    end
    if (tap_update_dr && instr_chain_scan) begin
      shadow_next.data = core_reg.data;
      shadow_next.ctrl = core_reg.ctrl;
    end
    if (instr_run_test) begin
      shadow_next.tdo = core_reg.bypass;
    end else if (instr_ctrl_scan) begin
      shadow_next.tdo = core_reg.test_op_select[0];
    end else begin
      shadow_next.tdo = core_reg.data[0];
    end
    shadow_next.test_mode = instr_run_test;
    // Active-low enables: A drives when b-to-a is low, B when a-to-b is low.
    shadow_next.a_oe = core_reg.run_flag && !shadow_next.ctrl[brt_pkg::OE_BA_POS];
    shadow_next.b_oe = core_reg.run_flag && !shadow_next.ctrl[brt_pkg::OE_AB_POS];
    if (rst_tck) begin
      shadow_next = '0;
      shadow_next.ctrl = brt_pkg::CTRL_RST;
    end
  end

  always_ff @(negedge tck) begin
    shadow_reg <= shadow_next;
  end

  // Pin, tdo and test_mode outputs come straight from the shadow flops; the sys_ outputs come from u_sys_sync.
  assign pin_a_out = shadow_reg.data[HW-1:0];
  assign pin_b_out = shadow_reg.data[2*HW-1:HW];
  assign pin_a_oe = shadow_reg.a_oe;
  assign pin_b_oe = shadow_reg.b_oe;
  assign tdo = shadow_reg.tdo;
  assign test_mode = shadow_reg.test_mode;

  // Checks on the rising-edge behaviour of the engine.
  property p_capture_hold;
    @(posedge tck) disable iff (rst_tck)
      instr_ctrl_scan && tap_capture_dr && !tap_shift_dr |=> $stable(core_reg.test_op_select);
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("select changed at capture");

  property p_bypass_zero;
    @(posedge tck) disable iff (rst_tck)
      instr_run_test && tap_capture_dr && !tap_shift_dr |=> core_reg.bypass == 1'b0;
  endproperty
  a_bypass_zero: assert property (p_bypass_zero) else $error("bypass did not capture 0");

  property p_decode_low;
    @(posedge tck) disable iff (rst_tck)
      core_reg.test_op_select[1:0] == 2'b01 |-> op == brt_pkg::BRT_OP_PATTERN;
  endproperty
  a_decode_low: assert property (p_decode_low) else $error("X01 not decoded");

  property p_decode_cnt;
    @(posedge tck) disable iff (rst_tck)
      core_reg.test_op_select == 3'b111 |-> op == brt_pkg::BRT_OP_SIG_CNT;
  endproperty
  a_decode_cnt: assert property (p_decode_cnt) else $error("111 not decoded");

  property p_idle_hold;
    @(posedge tck) disable iff (rst_tck)
      !run_active && !tap_shift_dr |=> $stable(core_reg.data);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("cells moved outside run");

  property p_ctrl_hold;
    @(posedge tck) disable iff (rst_tck)
      !(tap_shift_dr && instr_chain_scan) |=> $stable(core_reg.ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control cells changed");

  property p_equal_bypass;
    @(posedge tck) disable iff (rst_tck)
      instr_run_test && tap_run_idle
      && core_reg.ctrl[brt_pkg::OE_AB_POS] == core_reg.ctrl[brt_pkg::OE_BA_POS]
      |=> !core_reg.run_flag && $stable(core_reg.data);
  endproperty
  a_equal_bypass: assert property (p_equal_bypass) else $error("ran with equal enables");

  property p_toggle;
    @(posedge tck) disable iff (rst_tck)
      run_active && op == brt_pkg::BRT_OP_TOGGLE
      |=> out_cells == ~$past(out_cells) && in_cells == $past(in_pins);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle step wrong");

  property p_pattern;
    @(posedge tck) disable iff (rst_tck)
      run_active && op == brt_pkg::BRT_OP_PATTERN |=> ordered == $past(step40);
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern step wrong");

  property p_zero_seed;
    @(posedge tck) disable iff (rst_tck)
      run_active && op == brt_pkg::BRT_OP_PATTERN && core_reg.data == '0
      |=> core_reg.data == '0;
  endproperty
  a_zero_seed: assert property (p_zero_seed) else $error("zero seed did not stay zero");

  property p_count;
    @(posedge tck) disable iff (rst_tck)
      run_active && op == brt_pkg::BRT_OP_SIG_CNT |=> out_cells == $past(out_cells) + 20'h00001;
  endproperty
  a_count: assert property (p_count) else $error("counter did not step by one");

  c_toggle_run: cover property (@(posedge tck) disable iff (rst_tck)
    (run_active && op == brt_pkg::BRT_OP_TOGGLE) [*3]);
  c_signature_run: cover property (@(posedge tck) disable iff (rst_tck)
    (run_active && op == brt_pkg::BRT_OP_SIGNATURE) [*4]);
  c_count_run: cover property (@(posedge tck) disable iff (rst_tck)
    run_active && op == brt_pkg::BRT_OP_SIG_CNT ##1 run_active);
  c_select_scan: cover property (@(posedge tck) disable iff (rst_tck)
    (instr_ctrl_scan && tap_shift_dr) [*3]);

endmodule // brt_engine

// ### sim/brt_jtag_model.sv
// Behavioural JTAG test controller that sits in front of the run-test engine.
// Assumes the engine samples TAP decodes on rising tck and moves tdo on falling tck.
`timescale 1ns/1ps
module brt_jtag_model (
  output logic tck,
  output logic tdi,
  output logic instr_run_test,
  output logic instr_ctrl_scan,
  output logic instr_chain_scan,
  output logic tap_capture_dr,
  output logic tap_shift_dr,
  output logic tap_update_dr,
  output logic tap_run_idle,
  input wire logic tdo
);
  logic seen;

  // Test clock runs free so the engine can see reset; its phase is unrelated to sys_clk.
  initial begin
    {instr_run_test, instr_ctrl_scan, instr_chain_scan, tdi} = 4'h0;
    {tap_capture_dr, tap_shift_dr, tap_update_dr, tap_run_idle} = 4'h0;
    seen = 1'b0;
    tck = 1'b0;
    #7;
    forever #24 tck = ~tck;
  end

  // One TAP state per cycle, changed just after the falling edge so the rise sees it settled.
  // The tdo sample is taken first, before the new state can disturb it.
  task automatic step(input logic [2:0] ins, input logic [3:0] st, input logic d);
    @(negedge tck);
    #1;
    seen = tdo;
    {instr_chain_scan, instr_ctrl_scan, instr_run_test} = ins;
    {tap_update_dr, tap_capture_dr, tap_shift_dr, tap_run_idle} = st;
    tdi = d;
  endtask

  // Shifts n bits LSB first; dout[i] holds the chain bit seen after i shifts.
  task automatic shift(input logic [2:0] ins, input int n, input logic [63:0] din,
                       output logic [63:0] dout);
    dout = 64'h0;
    for (int i = 0; i < n; i++) begin
      step(ins, 4'h2, din[i]);
      dout[i] = seen;
    end
    step(ins, 4'h0, ~din[n-1]);
  endtask
endmodule // brt_jtag_model

// ### sim/brt_engine_tb.sv
// Self-checking bench for the boundary run-test engine.
// Assumes brt_jtag_model drives the TAP side; pins and reset are driven from here.
`timescale 1ns/1ps
module brt_engine_tb;
  typedef struct packed {
    logic [2:0] op;
    logic [1:0] en;
    logic [39:0] seed;
    logic [19:0] pins;
    logic [7:0] n;
    logic [1:0] oe;
  } brt_row_s;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic tck, tdi, tdo, i_run, i_ctl, i_chn, t_cap, t_sh, t_upd, t_idle;
  logic [19:0] a_in = 20'h00000;
  logic [19:0] b_in = 20'h00000;
  logic [19:0] a_out, b_out;
  logic a_oe, b_oe, test_mode, run_act;
  logic [2:0] op_code;
  logic [63:0] got, s;
  logic [51:0] e;
  int bad_count = 0;
  int cmp_count = 0;
  brt_row_s r;
  // Each row: operation, enables {47,46}, seed, input pins, steps, expected {a_oe,b_oe}.
  brt_row_s rows [10] = '{
    '{3'h0, 2'h1, 40'hA5A5A0F0F0, 20'h3C3C3, 8'h05, 2'h1},
    '{3'h4, 2'h2, 40'h0000012345, 20'h81818, 8'h04, 2'h2},
    '{3'h1, 2'h1, 40'h8000000001, 20'h00000, 8'h09, 2'h1},
    '{3'h2, 2'h1, 40'h0F0F0F0F0F, 20'hABCDE, 8'h07, 2'h1},
    '{3'h6, 2'h2, 40'h0000000000, 20'h55555, 8'h05, 2'h2},
    '{3'h3, 2'h1, 40'h1234500001, 20'h0F00F, 8'h08, 2'h1},
    '{3'h7, 2'h2, 40'h54321FFFFE, 20'h77777, 8'h04, 2'h2},
    '{3'h5, 2'h1, 40'h0000000000, 20'h00000, 8'h06, 2'h1},
    '{3'h3, 2'h2, 40'h0000000000, 20'h00000, 8'h05, 2'h2},
    '{3'h1, 2'h3, 40'hC0FFEE1234, 20'h2468A, 8'h05, 2'h0}
  };

  // System clock, 20 ns period.
  always #10 sys_clk = ~sys_clk;

  brt_engine brt_engine_i (.sys_clk(sys_clk), .rst(rst), .tck(tck), .tdi(tdi),
    .instr_run_test(i_run), .instr_ctrl_scan(i_ctl), .instr_chain_scan(i_chn),
    .tap_capture_dr(t_cap), .tap_shift_dr(t_sh), .tap_update_dr(t_upd),
    .tap_run_idle(t_idle), .pin_a_in(a_in), .pin_b_in(b_in), .pin_a_out(a_out),
    .pin_a_oe(a_oe), .pin_b_out(b_out), .pin_b_oe(b_oe), .tdo(tdo),
    .test_mode(test_mode), .sys_run_active(run_act), .sys_op_code(op_code));

  brt_jtag_model brt_jtag_model_i (.tck(tck), .tdi(tdi), .instr_run_test(i_run),
    .instr_ctrl_scan(i_ctl), .instr_chain_scan(i_chn), .tap_capture_dr(t_cap),
    .tap_shift_dr(t_sh), .tap_update_dr(t_upd), .tap_run_idle(t_idle), .tdo(tdo));

  // Reference step on {out,in}; written independently of the engine's helpers.
  function automatic logic [39:0] nxt(input logic [2:0] op, input logic [39:0] x,
                                      input logic [19:0] p);
    logic [19:0] o, i;
    o = x[39:20];
    i = x[19:0];
    if (op[1:0] == 2'h0) return {~o, p};
    if (op[1:0] == 2'h1) return {x[38:0], ^(x & brt_pkg::LFSR40_TAPS)};
    if (op[1:0] == 2'h2) return {x[38:0], ^(x & brt_pkg::LFSR40_TAPS)} ^ {20'h00000, p};
    o = op[2] ? o + 20'h00001 : {o[18:0], ^(o & brt_pkg::LFSR20_TAPS)};
    return {o, {i[18:0], ^(i & brt_pkg::LFSR20_TAPS)} ^ p};
  endfunction

  // Chain order to {out,in}: with B as input the halves trade places.
  function automatic logic [39:0] swap(input logic [1:0] en, input logic [39:0] x);
    return (en == 2'h2) ? {x[19:0], x[39:20]} : x;
  endfunction

  task automatic cmp(input logic [63:0] got_v, input logic [63:0] exp_v);
    cmp_count++;
    if (got_v !== exp_v) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch and still reaches the verdict.
  initial begin
    for (int k = 0; k < 50000; k++) @(posedge sys_clk);
    bad_count++;
    report_and_stop();
  end

  // Main sequence: reset, table of operations, the bypass capture case, then a second reset.
  initial begin
    repeat (12) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    repeat (6) brt_jtag_model_i.step(3'h0, 4'h0, 1'b0);
    cmp({a_oe, b_oe, test_mode, op_code, a_out, b_out}, 64'h0);
    foreach (rows[k]) begin
      r = rows[k];
      @(posedge sys_clk);
      #2;
      a_in = (r.en == 2'h2) ? ~r.pins : r.pins;
      b_in = (r.en == 2'h2) ? r.pins : ~r.pins;
      brt_jtag_model_i.shift(3'h2, 3, {61'h0, r.op}, got);
      brt_jtag_model_i.step(3'h2, 4'h4, 1'b0);
      brt_jtag_model_i.step(3'h0, 4'h0, 1'b0);
      cmp(op_code, r.op);
      brt_jtag_model_i.shift(3'h4, 52, {12'h0, r.en, 10'h155, r.seed}, got);
      brt_jtag_model_i.step(3'h4, 4'h8, 1'b0);
      s = {24'h0, swap(r.en, r.seed)};
      for (int j = 0; j < r.n; j++) begin
        if (r.oe != 2'h0) s[39:0] = nxt(r.op, s[39:0], r.pins);
      end
      repeat (r.n) brt_jtag_model_i.step(3'h1, 4'h1, 1'b0);
      brt_jtag_model_i.step(3'h1, 4'h0, 1'b0);
      cmp({a_oe, b_oe}, r.oe);
      cmp({test_mode, run_act}, {1'b1, r.oe != 2'h0});
      if (r.oe == 2'h1) cmp(b_out, r.op[1:0] == 2'h2 ? r.seed[39:20] : s[39:20]);
      if (r.oe == 2'h2) cmp(a_out, r.op[1:0] == 2'h2 ? r.seed[19:0] : s[39:20]);
      brt_jtag_model_i.shift(3'h4, 52, 64'h0, got);
      e = {r.en, 10'h155, swap(r.en, s[39:0])};
      cmp(got[51:1], e[51:1]);
    end
    brt_jtag_model_i.step(3'h1, 4'h2, 1'b1);
    brt_jtag_model_i.step(3'h1, 4'h4, 1'b0);
    cmp(brt_jtag_model_i.seen, 1'b1);
    brt_jtag_model_i.step(3'h1, 4'h0, 1'b0);
    cmp(brt_jtag_model_i.seen, 1'b0);
    // Reset with no run active, after the bypass case: the select register clears and the chain reads back its reset image.
    @(posedge sys_clk);
    #2;
    rst = 1'b1;
    repeat (8) brt_jtag_model_i.step(3'h0, 4'h0, 1'b0);
    @(posedge sys_clk);
    #2;
    rst = 1'b0;
    repeat (6) brt_jtag_model_i.step(3'h0, 4'h0, 1'b0);
    cmp({a_oe, b_oe, test_mode, run_act, op_code}, 64'h0);
    brt_jtag_model_i.shift(3'h4, 52, 64'h0, got);
    e = {brt_pkg::CTRL_RST, brt_pkg::DATA_RST};
    cmp(got[51:1], e[51:1]);
    report_and_stop();
  end
endmodule // brt_engine_tb
